// ---- hw/wtc_cfg.svh ----
/*
 * Constants of the wide timer block: register byte offsets, reset values,
 * field codes, status bit positions and prescaler tap exponents.
 * Assumes it is included by bare name once per compilation unit.
 */
`ifndef WTC_CFG_SVH
`define WTC_CFG_SVH

// Register byte offsets on the 8-bit bus address
`define WTC_OFF_CMP_LO   8'h00
`define WTC_OFF_CMP_MID  8'h04
`define WTC_OFF_CMP_UP   8'h08
`define WTC_OFF_GATE     8'h0C
`define WTC_OFF_STATUS   8'h10
`define WTC_OFF_CTRL     8'h14
`define WTC_OFF_IST      8'h18
`define WTC_OFF_ICLR     8'h1C
`define WTC_OFF_IEN      8'h20
`define WTC_OFF_CFG      8'h24

// Reset values
`define WTC_CTRL_RST     8'h88
`define WTC_CMP_RST      18'h3_FFFF
`define WTC_GATE_RST     8'h00
`define WTC_CFG_RST      4'h0

// Field codes
`define WTC_RUN_START    2'b10
`define WTC_OP_TIMER     2'b00
`define WTC_OP_FREQ      2'b11
`define WTC_SRC_EXT      3'b111

// Event bits in the sticky status, enable and clear registers
`define WTC_EV_MATCH     0
`define WTC_EV_OVF       1

// Bus responses
`define WTC_RESP_OKAY    2'b00
`define WTC_RESP_SLVERR  2'b10

// Prescaler tap exponents, fast then slow clock
`define WTC_FC_E23       23
`define WTC_FC_E14       14
`define WTC_FC_E13       13
`define WTC_FC_E12       12
`define WTC_FC_E11       11
`define WTC_FC_E7        7
`define WTC_FC_E3        3
`define WTC_FS_E15       15
`define WTC_FS_E6        6
`define WTC_FS_E5        5
`define WTC_FS_E4        4
`define WTC_FS_E3        3

`endif

// ---- hw/wtc_pkg.sv ----
/*
 * Types of the wide timer block: control layout, config layout, gate states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package wtc_pkg;

   // Layout of timer_control_one
   typedef struct packed {
      logic       clr_n;     // 0 clears counter and overflow
      logic [1:0] run;       // run_control
      logic [2:0] src;       // source_select
      logic [1:0] op;        // operation_select
   } wtc_ctrl_t;

   // Layout of the speed and gate config register
   typedef struct packed {
      logic [1:0] gate_sel;  // gate_prescale_select
      logic       low_speed; // low_speed_run or low_speed_halt
      logic       div_opt;   // divider_source_option
   } wtc_cfg_t;

   // Window gate phases, one-hot
   typedef enum logic [2:0] {
      GATE_IDLE = 3'b001,
      GATE_HIGH = 3'b010,
      GATE_LOW  = 3'b100
   } wtc_gate_t;

endpackage : wtc_pkg

// ---- hw/wtc_prescale.sv ----
/*
 * Free-running binary prescaler. Tap k-1 pulses once every 2^k input ticks.
 * Assumes i_tick is a one-cycle enable on i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module wtc_prescale #(
   parameter int W = 23
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_tick,
   output logic [W-1:0]      o_taps
);

   logic [W-1:0] count_q, count_d;   // Divider chain
   logic [W-1:0] taps_q,  taps_d;    // Registered tap pulses

   // Next count and carry-out pulses of each stage
   always_comb begin
      logic acc;
      acc     = i_tick;
      count_d = i_tick ? count_q + 1'b1 : count_q;
      for (int i = 0; i < W; i++) begin
         acc       = acc & count_q[i];
         taps_d[i] = acc;
      end
   end

   // Registers only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_q <= '0;
         taps_q  <= '0;
      end else begin
         count_q <= count_d;
         taps_q  <= taps_d;
      end
   end

   assign o_taps = taps_q;

endmodule : wtc_prescale

`default_nettype wire

// ---- hw/wtc_top.sv ----
/*
 * Wide timer control: AXI4-Lite register slave, 18-bit up-counter with
 * compare, source clock selection, window gate generator and interrupt.
 * Assumes I_CLK is the fast system clock; the slow clock and count pin
 * arrive asynchronously and are sampled here.
 */
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wtc_cfg.svh"

// Behaviour
// - hold 18-bit compare and 8-bit gate setting
// - gate high lasts 16 minus field periods
// - gate low lasts 16 minus field periods
// - source select picks clock or external pin
// - operation field selects timer, width, frequency
// - low and middle byte writes inhibit compare until upper
// - compare read returns live counter value
// - upper compare bits 7..2 read zero
// - match raises interrupt, clears, resumes counting
// - event mode counts pin falling edges
// - read-only counting and overflow status bits
module wtc_top (
   input  wire logic        I_CLK,
   input  wire logic        I_RSTN,
   input  wire logic        I_COUNT_PIN,
   input  wire logic        I_SLOW_CLK,
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   output logic [1:0]       O_BRESP,
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   input  wire logic [7:0]  I_ARADDR,
   output logic             O_RVALID,
   input  wire logic        I_RREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   output logic             O_IRQ
);

   // Tap of a prescaler vector by exponent
   function automatic logic tap(input logic [22:0] v, input int unsigned e);
      return v[e-1];
   endfunction : tap

   // Address decode shared by read and write paths
   function automatic logic mapped(input logic [7:0] a);
      return (a <= `WTC_OFF_CFG) && (a[1:0] == 2'b00);
   endfunction : mapped

   // Pin synchronisers and settled levels
   logic [2:0] pin_sync_q, pin_sync_d;
   logic [2:0] slw_sync_q, slw_sync_d;
   logic       pin_lvl_q, pin_lvl_d;
   logic       slw_lvl_q, slw_lvl_d;
   logic       ext_fall;              // Settled falling edge of count pin
   logic       slow_rise;             // Settled rising edge of slow clock

   // Sampling: a change counts once stages two and three agree
   always_comb begin
      pin_sync_d = {pin_sync_q[1:0], I_COUNT_PIN};
      slw_sync_d = {slw_sync_q[1:0], I_SLOW_CLK};
      pin_lvl_d  = (pin_sync_q[1] == pin_sync_q[2]) ? pin_sync_q[2] : pin_lvl_q;
      slw_lvl_d  = (slw_sync_q[1] == slw_sync_q[2]) ? slw_sync_q[2] : slw_lvl_q;
      ext_fall   = pin_lvl_q & ~pin_lvl_d;
      slow_rise  = ~slw_lvl_q & slw_lvl_d;
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         pin_sync_q <= 3'h7;      // Idle high avoids a false edge
         slw_sync_q <= 3'h0;
         pin_lvl_q  <= 1'b1;
         slw_lvl_q  <= 1'b0;
      end else begin
         pin_sync_q <= pin_sync_d;
         slw_sync_q <= slw_sync_d;
         pin_lvl_q  <= pin_lvl_d;
         slw_lvl_q  <= slw_lvl_d;
      end
   end

   // Prescalers for fast and slow clocks
   logic [22:0] fast_taps;
   logic [14:0] slow_taps;

   wtc_prescale #(.W(23)) u_fast (
      .i_clk   (I_CLK),
      .i_rst_n (I_RSTN),
      .i_tick  (1'b1),
      .o_taps  (fast_taps)
   );

   wtc_prescale #(.W(15)) u_slow (
      .i_clk   (I_CLK),
      .i_rst_n (I_RSTN),
      .i_tick  (slow_rise),
      .o_taps  (slow_taps)
   );

   // Register state
   wtc_pkg::wtc_ctrl_t ctrl_q, ctrl_d;   // timer_control_one
   wtc_pkg::wtc_cfg_t  cfg_q,  cfg_d;    // Speed and gate options
   logic [17:0] cmp_q, cmp_d;            // compare_value
   logic [7:0]  gate_q, gate_d;          // window_gate_setting
   logic        inh_q, inh_d;            // Compare inhibited
   logic [1:0]  ist_q, ist_d;            // Sticky events
   logic [1:0]  ien_q, ien_d;            // Event enables
   logic        clr_cnt;                 // Counter clear by write

   // Bus state
   logic        aw_full_q, aw_full_d;
   logic [7:0]  awaddr_q, awaddr_d;
   logic        w_full_q, w_full_d;
   logic [31:0] wdata_q, wdata_d;
   logic        wstrb0_q, wstrb0_d;
   logic        bvalid_q, bvalid_d;
   logic [1:0]  bresp_q, bresp_d;
   logic        rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0]  rresp_q, rresp_d;
   logic        wr_go;                   // Both halves held, do write
   logic        rd_go;                   // Read address taken

   // Counter state
   logic [17:0] cnt_q, cnt_d;
   logic        ovf_q, ovf_d;
   wtc_pkg::wtc_gate_t gst_q, gst_d;
   logic [3:0]  gcnt_q, gcnt_d;
   logic        ev_match, ev_ovf;
   logic        src_tick, gate_tick, count_en, run;

   // AXI4-Lite handshakes; address and data in either order
   assign O_AWREADY = ~aw_full_q;
   assign O_WREADY  = ~w_full_q;
   assign O_ARREADY = ~rvalid_q;
   assign wr_go     = aw_full_q & w_full_q & ~bvalid_q;
   assign rd_go     = I_ARVALID & ~rvalid_q;

   always_comb begin
      aw_full_d = aw_full_q;
      awaddr_d  = awaddr_q;
      w_full_d  = w_full_q;
      wdata_d   = wdata_q;
      wstrb0_d  = wstrb0_q;
      bvalid_d  = bvalid_q & ~I_BREADY;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q & ~I_RREADY;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (I_AWVALID && !aw_full_q) begin
         aw_full_d = 1'b1;
         awaddr_d  = I_AWADDR;
      end
      if (I_WVALID && !w_full_q) begin
         w_full_d = 1'b1;
         wdata_d  = I_WDATA;
         wstrb0_d = I_WSTRB[0];
      end
      if (wr_go) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = mapped(awaddr_q) ? `WTC_RESP_OKAY : `WTC_RESP_SLVERR;
      end
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d  = mapped(I_ARADDR) ? `WTC_RESP_OKAY : `WTC_RESP_SLVERR;
         rdata_d  = '0;
         // Compare reads give the live count
         if (I_ARADDR == `WTC_OFF_CMP_LO) begin
            rdata_d[7:0] = cnt_q[7:0];
         end else if (I_ARADDR == `WTC_OFF_CMP_MID) begin
            rdata_d[7:0] = cnt_q[15:8];
         end else if (I_ARADDR == `WTC_OFF_CMP_UP) begin
            rdata_d[1:0] = cnt_q[17:16];   // Bits 7..2 stay zero
         end else if (I_ARADDR == `WTC_OFF_GATE) begin
            rdata_d[7:0] = gate_q;
         end else if (I_ARADDR == `WTC_OFF_STATUS) begin
            rdata_d[7:6] = {gst_q == wtc_pkg::GATE_HIGH, ovf_q};
         end else if (I_ARADDR == `WTC_OFF_CTRL) begin
            rdata_d[7:0] = ctrl_q;
         end else if (I_ARADDR == `WTC_OFF_IST) begin
            rdata_d[1:0] = ist_q;
         end else if (I_ARADDR == `WTC_OFF_IEN) begin
            rdata_d[1:0] = ien_q;
         end else if (I_ARADDR == `WTC_OFF_CFG) begin
            rdata_d[3:0] = cfg_q;
         end
      end
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         aw_full_q <= 1'b0;
         awaddr_q  <= 8'h00;
         w_full_q  <= 1'b0;
         wdata_q   <= 32'h0000_0000;
         wstrb0_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `WTC_RESP_OKAY;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `WTC_RESP_OKAY;
      end else begin
         aw_full_q <= aw_full_d;
         awaddr_q  <= awaddr_d;
         w_full_q  <= w_full_d;
         wdata_q   <= wdata_d;
         wstrb0_q  <= wstrb0_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   assign O_BVALID = bvalid_q;
   assign O_BRESP  = bresp_q;
   assign O_RVALID = rvalid_q;
   assign O_RDATA  = rdata_q;
   assign O_RRESP  = rresp_q;

   // Register writes; only byte lane 0 carries data
   always_comb begin
      logic [1:0] clr_mask;
      clr_mask = 2'b00;
      clr_cnt  = 1'b0;
      ctrl_d   = ctrl_q;
      cfg_d    = cfg_q;
      cmp_d    = cmp_q;
      gate_d   = gate_q;
      inh_d    = inh_q;
      ien_d    = ien_q;
      if (wr_go && wstrb0_q) begin
         if (awaddr_q == `WTC_OFF_CTRL) begin
            ctrl_d  = wdata_q[7:0];
            clr_cnt = ~wdata_q[7];         // Clear counter and overflow
         end else if (awaddr_q == `WTC_OFF_CMP_LO) begin
            cmp_d[7:0] = wdata_q[7:0];
            inh_d      = 1'b1;
         end else if (awaddr_q == `WTC_OFF_CMP_MID) begin
            cmp_d[15:8] = wdata_q[7:0];
            inh_d       = 1'b1;
         end else if (awaddr_q == `WTC_OFF_CMP_UP) begin
            cmp_d[17:16] = wdata_q[1:0];   // Ones above bit 1 dropped
            inh_d        = 1'b0;
         end else if (awaddr_q == `WTC_OFF_GATE) begin
            gate_d = wdata_q[7:0];
         end else if (awaddr_q == `WTC_OFF_ICLR) begin
            clr_mask = wdata_q[1:0];
         end else if (awaddr_q == `WTC_OFF_IEN) begin
            ien_d = wdata_q[1:0];
         end else if (awaddr_q == `WTC_OFF_CFG) begin
            cfg_d = wdata_q[3:0];
         end
      end
      // An event in the clearing cycle survives
      ist_d = (ist_q & ~clr_mask) | {ev_ovf, ev_match};
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         ctrl_q <= `WTC_CTRL_RST;
         cfg_q  <= `WTC_CFG_RST;
         cmp_q  <= `WTC_CMP_RST;
         gate_q <= `WTC_GATE_RST;
         inh_q  <= 1'b0;
         ist_q  <= 2'b00;
         ien_q  <= 2'b00;
      end else begin
         ctrl_q <= ctrl_d;
         cfg_q  <= cfg_d;
         cmp_q  <= cmp_d;
         gate_q <= gate_d;
         inh_q  <= inh_d;
         ist_q  <= ist_d;
         ien_q  <= ien_d;
      end
   end

   assign O_IRQ = |(ist_q & ien_q);

   // Source and gate clock selection; slow taps for source codes 010-100 and the gate in low-speed or divider mode
   always_comb begin
      logic sl;
      logic [22:0] st;
      sl        = cfg_q.div_opt | cfg_q.low_speed;
      st        = {8'h00, slow_taps};
      run       = (ctrl_q.run == `WTC_RUN_START);
      case (ctrl_q.src)
         3'b000:  src_tick = 1'b1;
         3'b001:  src_tick = slow_rise;
         3'b010:  src_tick = sl ? tap(st, `WTC_FS_E15) : tap(fast_taps, `WTC_FC_E23);
         3'b011:  src_tick = sl ? tap(st, `WTC_FS_E5) : tap(fast_taps, `WTC_FC_E13);
         3'b100:  src_tick = sl ? tap(st, `WTC_FS_E3) : tap(fast_taps, `WTC_FC_E11);
         3'b101:  src_tick = tap(fast_taps, `WTC_FC_E7);
         3'b110:  src_tick = tap(fast_taps, `WTC_FC_E3);
         default: src_tick = ext_fall;
      endcase
      case (cfg_q.gate_sel)
         2'b00:   gate_tick = sl ? tap(st, `WTC_FS_E4) : tap(fast_taps, `WTC_FC_E12);
         2'b01:   gate_tick = sl ? tap(st, `WTC_FS_E5) : tap(fast_taps, `WTC_FC_E13);
         2'b10:   gate_tick = sl ? tap(st, `WTC_FS_E6) : tap(fast_taps, `WTC_FC_E14);
         default: gate_tick = 1'b0;                     // Reserved code
      endcase
   end

   // Counter, compare and window gate
   always_comb begin
      logic [18:0] inc;
      inc      = {1'b0, cnt_q} + 19'h0_0001;
      cnt_d    = cnt_q;
      gst_d    = gst_q;
      gcnt_d   = gcnt_q;
      ev_match = 1'b0;
      ev_ovf   = 1'b0;
      // Frequency mode counts only inside the gate window
      count_en = run & src_tick &
                 ((ctrl_q.op != `WTC_OP_FREQ) | (gst_q == wtc_pkg::GATE_HIGH));
      if (!run) begin
         cnt_d = '0;
         gst_d = wtc_pkg::GATE_IDLE;
      end else begin
         case (gst_q)
            wtc_pkg::GATE_IDLE: begin
               gst_d  = wtc_pkg::GATE_HIGH;
               gcnt_d = gate_q[7:4];
            end
            wtc_pkg::GATE_HIGH: begin
               if (gate_tick) begin
                  gst_d  = (gcnt_q == 4'hF) ? wtc_pkg::GATE_LOW : gst_q;
                  gcnt_d = (gcnt_q == 4'hF) ? gate_q[3:0] : gcnt_q + 4'h1;
               end
            end
            wtc_pkg::GATE_LOW: begin
               if (gate_tick) begin
                  gst_d  = (gcnt_q == 4'hF) ? wtc_pkg::GATE_HIGH : gst_q;
                  gcnt_d = (gcnt_q == 4'hF) ? gate_q[7:4] : gcnt_q + 4'h1;
               end
            end
            default: gst_d = wtc_pkg::GATE_IDLE;
         endcase
         if (count_en) begin
            // Full-width match in timer/event mode
            if (!inh_q && ctrl_q.op == `WTC_OP_TIMER && inc[17:0] == cmp_q) begin
               cnt_d    = '0;
               ev_match = 1'b1;
            end else begin
               cnt_d  = inc[17:0];
               ev_ovf = inc[18];
            end
         end
      end
      if (clr_cnt) begin
         cnt_d = '0;
      end
      ovf_d = (ovf_q & ~clr_cnt) | ev_ovf;
   end

   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         cnt_q  <= '0;
         ovf_q  <= 1'b0;
         gst_q  <= wtc_pkg::GATE_IDLE;
         gcnt_q <= 4'h0;
      end else begin
         cnt_q  <= cnt_d;
         ovf_q  <= ovf_d;
         gst_q  <= gst_d;
         gcnt_q <= gcnt_d;
      end
   end

   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);

   up_zero_a: assert property (rd_go && I_ARADDR == `WTC_OFF_CMP_UP |=>
      O_RDATA[31:2] == '0)
      else $error("upper compare read has nonzero high bits");
   live_read_a: assert property (rd_go && I_ARADDR == `WTC_OFF_CMP_LO |=>
      O_RDATA[7:0] == $past(cnt_q[7:0]))
      else $error("compare read is not the live count");
   inhibit_a: assert property (wr_go && wstrb0_q && awaddr_q == `WTC_OFF_CMP_MID |=>
      inh_q && !ev_match)
      else $error("compare not inhibited after middle byte write");
   match_clear_a: assert property (ev_match |=> cnt_q == '0 && ist_q[`WTC_EV_MATCH])
      else $error("match did not clear and flag");
   match_width_a: assert property (ev_match |-> cnt_q + 18'h0_0001 == cmp_q)
      else $error("match on partial compare");
   stop_clear_a: assert property (!run |=> cnt_q == '0)
      else $error("stopped counter not cleared");
   gate_fall_a: assert property (gst_q == wtc_pkg::GATE_HIGH && run && gate_tick &&
      gcnt_q == 4'hF |=> gst_q == wtc_pkg::GATE_LOW && gcnt_q == $past(gate_q[3:0]))
      else $error("gate high phase ended wrongly");
   gate_rise_a: assert property (gst_q == wtc_pkg::GATE_LOW && run && gate_tick &&
      gcnt_q == 4'hF |=> gst_q == wtc_pkg::GATE_HIGH)
      else $error("gate low phase ended wrongly");
   ext_count_a: assert property (run && ctrl_q.src == `WTC_SRC_EXT &&
      ctrl_q.op == `WTC_OP_TIMER |-> count_en == ext_fall)
      else $error("event count not tied to pin edge");
   ovf_flag_a: assert property (ev_ovf |=> ovf_q && ist_q[`WTC_EV_OVF])
      else $error("overflow not reported");

endmodule : wtc_top

`default_nettype wire

// ---- verif/wtc_pin_model.sv ----
/*
 * Stand-in for the source on the external count pin.
 * Assumes the block's clock; the pin idles high between pulses.
 */
`timescale 1ns/1ps
`default_nettype none

module wtc_pin_model (
   input  wire logic i_clk,
   output logic      o_pin
);
   // Idle high, so only deliberate pulses give falling edges
   initial o_pin = 1'b1;

   // Low held 3 cycles, high 4 between pulses, above the two-cycle minimum
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge i_clk);
         o_pin <= 1'b0;
         repeat (3) @(posedge i_clk);
         o_pin <= 1'b1;
         repeat (3) @(posedge i_clk);
      end
   endtask : pulse
endmodule : wtc_pin_model

`default_nettype wire

// ---- verif/testbench.sv ----
/*
 * Self-checking bench: AXI4-Lite tasks, then register, timer, event
 * and window gate tests. Assumes a free slow clock beside the fast one.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        clk   = 1'b0;   // Fast clock
   logic        slw   = 1'b0;   // Slow clock
   logic        rst_n = 1'b0;   // Async reset
   logic        awv   = 1'b0;   // Write address valid
   logic        wv    = 1'b0;   // Write data valid
   logic        br    = 1'b0;   // Response ready
   logic        arv   = 1'b0;   // Read address valid
   logic        rr    = 1'b0;   // Read data ready
   logic [7:0]  aa    = 8'h0;   // Write address
   logic [7:0]  ra    = 8'h0;   // Read address
   logic [31:0] wd    = 32'h0;  // Write data
   logic [31:0] rdat;           // Last read data
   logic [1:0]  rsp;            // Last response
   logic        pin, awr, wrdy, bv, arr, rv, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          errors  = 0;
   int          checked = 0;
   time         t0, t1;

   always #10 clk = ~clk;

   wtc_pin_model pm (.i_clk(clk), .o_pin(pin));

   // Slow clock free and unrelated to clk; strobe tied, lane 0 always written
   always #173 slw = ~slw;

   wtc_top dut (
      .I_CLK(clk), .I_RSTN(rst_n), .I_COUNT_PIN(pin), .I_SLOW_CLK(slw),
      .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(aa), .I_WVALID(wv),
      .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv),
      .I_BREADY(br), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr),
      .I_ARADDR(ra), .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_IRQ(irq)
   );

   // Address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awv <= 1'b1;
      wv  <= 1'b1;
      aa  <= a;
      wd  <= d;
      br  <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end while (!bv);
      rsp = bresp;
      br <= 1'b0;
   endtask : wr

   // Read; data and response taken at the edge with rvalid high
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      arv <= 1'b1;
      ra  <= a;
      rr  <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!rv);
      rdat = rdata;
      rsp  = rresp;
      rr <= 1'b0;
   endtask : rd

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   // Poll the counting bit; bounded so a stuck gate cannot hang
   task automatic waitbit(input logic v);
      int n;
      n = 0;
      do begin
         rd(8'h10);
         n++;
      end while (rdat[7] !== v && n < 3000);
   endtask : waitbit

   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // Watchdog well above the roughly 16k cycles of the tests
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      wrap_up();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h14); chk(rdat, 32'h88);
      rd(8'h0C); chk(rdat, 32'h0);
      wr(8'h0C, 32'hA5); rd(8'h0C); chk(rdat, 32'hA5);
      wr(8'h08, 32'hFF); rd(8'h08); chk(rdat, 32'h0);
      wr(8'h40, 32'h1); chk({30'h0, rsp}, 32'h2);
      rd(8'h40); chk({30'h0, rsp}, 32'h2);
      $display("test registers done");
      // Lower bytes only: matching must stay off while running
      wr(8'h20, 32'h1);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h3);
      wr(8'h04, 32'h0);
      wr(8'h1C, 32'h3);
      wr(8'h14, 32'h98);
      wr(8'h14, 32'hD8);
      repeat (40) @(posedge clk);
      rd(8'h18); chk(rdat, 32'h0);
      // Upper bits set: a partial compare would still match
      wr(8'h14, 32'h98);
      wr(8'h08, 32'h1);
      wr(8'h14, 32'hD8);
      repeat (40) @(posedge clk);
      rd(8'h18); chk(rdat, 32'h0);
      wr(8'h14, 32'h98);
      wr(8'h08, 32'h0);
      wr(8'h14, 32'hD8);
      repeat (40) @(posedge clk);
      rd(8'h18); chk(rdat, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(8'h20, 32'h0); chk({31'h0, irq}, 32'h0);
      wr(8'h20, 32'h1); chk({31'h0, irq}, 32'h1);
      wr(8'h14, 32'h98);
      wr(8'h1C, 32'h1); chk({31'h0, irq}, 32'h0);
      rd(8'h00); chk(rdat, 32'h0);
      $display("test timer done");
      // Event counting from the pin, settings changed while stopped
      wr(8'h14, 32'h9C);
      wr(8'h14, 32'hDC);
      pm.pulse(2);
      repeat (8) @(posedge clk);
      rd(8'h00); chk(rdat, 32'h2);
      pm.pulse(1);
      repeat (8) @(posedge clk);
      rd(8'h18); chk(rdat, 32'h1);
      rd(8'h00); chk(rdat, 32'h0);
      wr(8'h14, 32'h9C);
      $display("test event done");
      // Width mode on the undivided clock runs past compare unmatched
      wr(8'h14, 32'h82);
      wr(8'h1C, 32'h3);
      wr(8'h14, 32'hC2);
      repeat (20) @(posedge clk);
      rd(8'h18); chk(rdat, 32'h0);
      // Low speed: code 100 takes the slow tap, far quicker than fast/2^11
      wr(8'h14, 32'h82);
      wr(8'h24, 32'h2);
      wr(8'h14, 32'h90);
      wr(8'h14, 32'hD0);
      repeat (600) @(posedge clk);
      rd(8'h18); chk(rdat, 32'h1);
      wr(8'h14, 32'h90);
      $display("test modes done");
      // Gate fields 15: one tick of 4096 cycles each phase
      wr(8'h0C, 32'hFF);
      wr(8'h24, 32'h0);
      wr(8'h14, 32'h9B);
      wr(8'h14, 32'hDB);
      rd(8'h10); chk(rdat & 32'h80, 32'h80);
      waitbit(1'b0);
      waitbit(1'b1);
      t0 = $time;
      waitbit(1'b0);
      t1 = $time;
      chk(32'(int'((t1 - t0) / 20) inside {[4088:4104]}), 32'h1);
      waitbit(1'b1);
      t0 = $time;
      chk(32'(int'((t0 - t1) / 20) inside {[4088:4104]}), 32'h1);
      $display("test gate done");
      wrap_up();
   end
endmodule : testbench

`default_nettype wire
